// ==== src/lmr_pkg.sv ====
// shared constants, codes and helpers for the literal/move/return executor
`default_nettype none
package lmr_pkg;
    // register byte offsets on the control bus
    localparam logic [5:0] REG_INSTR = 6'h00;
    localparam logic [5:0] REG_ACC = 6'h04;
    localparam logic [5:0] REG_BANK = 6'h08;
    localparam logic [5:0] REG_PCH = 6'h0C;
    localparam logic [5:0] REG_FSR0 = 6'h10;
    localparam logic [5:0] REG_FSR1 = 6'h14;
    localparam logic [5:0] REG_INTCTL = 6'h18;
    localparam logic [5:0] REG_PWRCTL = 6'h1C;
    localparam logic [5:0] REG_PC = 6'h20;
    localparam logic [5:0] REG_STATUS = 6'h24;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // instruction word layout: opcode above an 8-bit argument
    localparam int OP_LSB = 8;
    localparam int OP_W = 4;
    localparam int ARG_W = 8;
    localparam int BANK_W = 5;
    localparam int PCH_W = 7;
    localparam int FADDR_W = 7;
    localparam int PTR_W = 16;
    localparam int K_W = 6;
    localparam int IND_SEL_BIT = 7;
    localparam int IND_REL_BIT = 6;
    localparam int INSTR_BUSY_BIT = 31;
    // control bit positions
    localparam int GIE_BIT = 7;
    localparam int RI_BIT = 2;
    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic [7:0] INTCTL_RST = 8'h00;
    localparam logic RI_RST = 1'b1;
    localparam logic [7:0] STATUS_RST = 8'h00;
    // window aliases inside each bank
    localparam logic [6:0] WIN0_ADDR = 7'h00;
    localparam logic [6:0] WIN1_ADDR = 7'h01;
    // pointer steps
    localparam logic [15:0] PTR_ONE = 16'h0001;
    localparam logic [15:0] PTR_MINUS_ONE = 16'hFFFF;
    // addressing mode codes
    localparam logic [1:0] MODE_PRE_INC = 2'b00;
    localparam logic [1:0] MODE_PRE_DEC = 2'b01;
    localparam logic [1:0] MODE_POST_INC = 2'b10;
    localparam logic [1:0] MODE_POST_DEC = 2'b11;
    // opcodes
    typedef enum logic [3:0] {
        OP_IDLE = 4'h0,
        OP_LD_BANK = 4'h1,
        OP_LD_PCH = 4'h2,
        OP_LD_ACC = 4'h3,
        OP_ST_FILE = 4'h4,
        OP_ST_IND = 4'h5,
        OP_SW_RESET = 4'h6,
        OP_RET_IRQ = 4'h7
    } lmr_op_t;
    // return sequencer states
    typedef enum logic [1:0] {
        RS_IDLE = 2'b00,
        RS_SECOND = 2'b01
    } lmr_state_t;
    // 16-bit pointer add, wraps both ways
    function automatic logic [15:0] lmr_ptr_add(input logic [15:0] p,
                                                input logic [15:0] d);
        return p + d;
    endfunction
endpackage
`default_nettype wire

// ==== src/lmr_ptr_calc.sv ====
// address and next-pointer calculation for the indirect store
`default_nettype none
module lmr_ptr_calc
    import lmr_pkg::*;
(
    input wire logic [15:0] fsr,
    input wire logic [1:0] mode,
    input wire logic rel,
    input wire logic [5:0] k,
    output logic [15:0] ea,
    output logic [15:0] fsr_nxt
);
    // signed offset widened to pointer width
    wire logic [15:0] k_ext = {{(PTR_W - K_W){k[K_W-1]}}, k};
    // odd mode codes step down, even ones step up
    wire logic [15:0] step = mode[0] ? PTR_MINUS_ONE : PTR_ONE;
    // pre modes use the moved pointer as the address
    wire logic pre = (mode == MODE_PRE_INC) || (mode == MODE_PRE_DEC);
    // wrap at both ends comes free from 16-bit arithmetic
    wire logic [15:0] moved = lmr_ptr_add(fsr, step);
    wire logic [15:0] offs = lmr_ptr_add(fsr, k_ext);

    // relative form never touches the pointer
    assign ea = rel ? offs : (pre ? moved : fsr);
    assign fsr_nxt = rel ? fsr : moved;
endmodule
`default_nettype wire

// ==== src/lmr_ret_seq.sv ====
// two-cycle return-from-interrupt sequencer
`default_nettype none
module lmr_ret_seq
    import lmr_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic start,
    output logic pop,
    output logic busy
);
    lmr_state_t state_r; // current phase
    lmr_state_t state_nxt; // next phase

    // pop happens in the first cycle only
    assign pop = start && (state_r == RS_IDLE);
    assign busy = (state_r != RS_IDLE);

    // next-state decode
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            RS_IDLE:
            begin
                if (start)
                    state_nxt = RS_SECOND;
            end
            RS_SECOND:
                state_nxt = RS_IDLE;
            default:
                state_nxt = RS_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge mclk)
    begin
        if (rst)
            state_r <= RS_IDLE;
        else
            state_r <= state_nxt;
    end

    sequence pop_seq;
        pop;
    endsequence
    sequence hold_seq;
        busy ##1 !busy;
    endsequence
    ret_two_cycle_a: assert property (@(posedge mclk) disable iff (rst)
        pop_seq |=> hold_seq)
        else $error("return did not take two cycles");
endmodule
`default_nettype wire

// ==== src/lmr_exec.sv ====
// executor for literal loads, stores, software reset and interrupt return
`default_nettype none
module lmr_exec
    import lmr_pkg::*;
#(
    parameter int PC_W = 15
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic awvalid,
    output logic awready,
    input wire logic [5:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [5:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic dm_we,
    output logic [15:0] dm_addr,
    output logic [7:0] dm_wdata,
    output logic stk_pop,
    input wire logic [PC_W-1:0] stack_top,
    output logic dev_reset_req,
    output logic [PC_W-1:0] pc
);
    // byte-lane merge used by the accumulator, file pointer, interrupt control and status writes
    function automatic logic [15:0] be_merge(input logic [15:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0])
            r[7:0] = d[7:0];
        if (be[1])
            r[15:8] = d[15:8];
        return r;
    endfunction

    // write channel holding registers
    logic aw_full_r; // address held
    logic [5:0] awaddr_r; // held address
    logic w_full_r; // data held
    logic [31:0] wdata_r; // held data
    logic [3:0] wstrb_r; // held strobes
    logic bvalid_r; // response pending
    logic [1:0] bresp_r; // response code
    // read channel
    logic rvalid_r; // read data pending
    logic [31:0] rdata_r; // read data
    logic [1:0] rresp_r; // read response
    // architectural state
    logic [7:0] acc_r; // accumulator
    logic [4:0] bank_r; // bank select
    logic [6:0] pch_r; // pc-high latch
    logic [15:0] fsr0_r; // first file pointer
    logic [15:0] fsr1_r; // second file pointer
    logic [7:0] intctl_r; // interrupt control
    logic ri_r; // software reset flag
    logic [7:0] status_r; // status flags
    logic [PC_W-1:0] pc_r; // program counter
    logic [7:0] last_r; // last instruction argument
    logic [3:0] lastop_r; // last opcode
    logic soft_rst_r; // one-cycle reset request
    // memory port registers
    logic dm_we_r;
    logic [15:0] dm_addr_r;
    logic [7:0] dm_wdata_r;

    // handshake decode; no new transfer on a channel while that channel's response is pending
    assign awready = !aw_full_r && !bvalid_r;
    assign wready = !w_full_r && !bvalid_r;
    assign arready = !rvalid_r;
    wire logic wr_go = aw_full_r && w_full_r && !bvalid_r;
    wire logic ar_go = arvalid && arready;

    // write address decode
    wire logic wa_instr = (awaddr_r == REG_INSTR);
    wire logic wa_acc = (awaddr_r == REG_ACC);
    wire logic wa_fsr0 = (awaddr_r == REG_FSR0);
    wire logic wa_fsr1 = (awaddr_r == REG_FSR1);
    wire logic wa_intctl = (awaddr_r == REG_INTCTL);
    wire logic wa_pwrctl = (awaddr_r == REG_PWRCTL);
    wire logic wa_status = (awaddr_r == REG_STATUS);
    // bank, pc-high and pc are read-only from the bus
    wire logic wa_ro = (awaddr_r == REG_BANK) ||
                       (awaddr_r == REG_PCH) || (awaddr_r == REG_PC);
    wire logic wa_hit = wa_instr || wa_acc || wa_fsr0 || wa_fsr1 ||
                        wa_intctl || wa_pwrctl || wa_status || wa_ro;

    // sequencer state
    wire logic busy;
    wire logic ret_pop;
    // an instruction arriving while busy is refused
    wire logic refuse = wa_instr && busy;
    wire logic wr_ok = wr_go && wa_hit && !wa_ro && !refuse;
    // merged bus words for the narrow registers, low byte used
    wire logic [15:0] acc_mrg = be_merge({8'h00, acc_r}, wdata_r, wstrb_r);
    wire logic [15:0] ictl_mrg = be_merge({8'h00, intctl_r}, wdata_r,
                                          wstrb_r);
    wire logic [15:0] stat_mrg = be_merge({8'h00, status_r}, wdata_r,
                                          wstrb_r);

    // instruction field decode
    wire lmr_op_t op = lmr_op_t'(wdata_r[OP_LSB +: OP_W]);
    wire logic [7:0] arg = wdata_r[ARG_W-1:0];
    wire logic exec = wr_go && wa_instr && !busy;
    wire logic ex_bank = exec && (op == OP_LD_BANK);
    wire logic ex_pch = exec && (op == OP_LD_PCH);
    wire logic ex_acc = exec && (op == OP_LD_ACC);
    wire logic ex_file = exec && (op == OP_ST_FILE);
    wire logic ex_ind = exec && (op == OP_ST_IND);
    wire logic ex_srst = exec && (op == OP_SW_RESET);
    wire logic ex_ret = exec && (op == OP_RET_IRQ);

    // direct store: window aliases go through a pointer
    wire logic [6:0] faddr = arg[FADDR_W-1:0];
    wire logic win0 = (faddr == WIN0_ADDR);
    wire logic win1 = (faddr == WIN1_ADDR);
    wire logic [15:0] banked = {{(PTR_W - BANK_W - FADDR_W){1'b0}},
                                bank_r, faddr};
    wire logic [15:0] file_ea = win0 ? fsr0_r :
                                (win1 ? fsr1_r : banked);

    // indirect store: pointer select and step
    wire logic ind_sel = arg[IND_SEL_BIT];
    wire logic [15:0] ind_fsr = ind_sel ? fsr1_r : fsr0_r;
    wire logic [15:0] ind_ea;
    wire logic [15:0] ind_nxt;

    lmr_ptr_calc u_ptr (
        .fsr(ind_fsr),
        .mode(arg[1:0]),
        .rel(arg[IND_REL_BIT]),
        .k(arg[K_W-1:0]),
        .ea(ind_ea),
        .fsr_nxt(ind_nxt)
    );

    lmr_ret_seq u_ret (
        .mclk(mclk),
        .rst(rst),
        .start(ex_ret),
        .pop(ret_pop),
        .busy(busy)
    );

    // write channel capture and response
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            awaddr_r <= 6'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end
        else
        begin
            // address and data may come in either order
            if (awvalid && awready)
            begin
                aw_full_r <= 1'b1;
                awaddr_r <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_full_r <= 1'b1;
                wdata_r <= wdata;
                wstrb_r <= wstrb;
            end
            if (wr_go)
            begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_r && bready)
                bvalid_r <= 1'b0;
        end
    end

    // read data mux, unmapped reads answer an error
    logic [31:0] rd_mux;
    logic rd_hit;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (araddr)
            REG_INSTR:
            begin
                rd_mux[INSTR_BUSY_BIT] = busy;
                rd_mux[OP_LSB +: OP_W] = lastop_r;
                rd_mux[ARG_W-1:0] = last_r;
            end
            REG_ACC: rd_mux[7:0] = acc_r;
            REG_BANK: rd_mux[BANK_W-1:0] = bank_r;
            REG_PCH: rd_mux[PCH_W-1:0] = pch_r;
            REG_FSR0: rd_mux[PTR_W-1:0] = fsr0_r;
            REG_FSR1: rd_mux[PTR_W-1:0] = fsr1_r;
            REG_INTCTL: rd_mux[7:0] = intctl_r;
            REG_PWRCTL: rd_mux[RI_BIT] = ri_r;
            REG_PC: rd_mux[PC_W-1:0] = pc_r;
            REG_STATUS: rd_mux[7:0] = status_r;
            default: rd_hit = 1'b0;
        endcase
    end

    // read channel
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end
        else if (ar_go)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_r && rready)
            rvalid_r <= 1'b0;
    end

    // literal loads, all single-cycle; soft reset clears them too
    always_ff @(posedge mclk)
    begin
        if (rst || soft_rst_r)
        begin
            acc_r <= ACC_RST;
            bank_r <= 5'h00;
            pch_r <= 7'h00;
        end
        else
        begin
            if (ex_acc)
                acc_r <= arg;
            else if (wr_ok && wa_acc)
                acc_r <= acc_mrg[7:0];
            if (ex_bank)
                bank_r <= arg[BANK_W-1:0];
            if (ex_pch)
                pch_r <= arg[PCH_W-1:0];
        end
    end

    // file pointers: stepped by indirect stores, else by the bus
    always_ff @(posedge mclk)
    begin
        if (rst || soft_rst_r)
        begin
            fsr0_r <= PTR_RST;
            fsr1_r <= PTR_RST;
        end
        else if (ex_ind)
        begin
            if (ind_sel)
                fsr1_r <= ind_nxt;
            else
                fsr0_r <= ind_nxt;
        end
        else
        begin
            if (wr_ok && wa_fsr0)
                fsr0_r <= be_merge(fsr0_r, wdata_r, wstrb_r);
            if (wr_ok && wa_fsr1)
                fsr1_r <= be_merge(fsr1_r, wdata_r, wstrb_r);
        end
    end

    // interrupt control, return, status and program counter
    always_ff @(posedge mclk)
    begin
        if (rst || soft_rst_r)
        begin
            intctl_r <= INTCTL_RST;
            status_r <= STATUS_RST;
            pc_r <= '0;
        end
        else
        begin
            if (wr_ok && wa_intctl)
                intctl_r <= ictl_mrg[7:0];
            if (ret_pop)
            begin
                intctl_r[GIE_BIT] <= 1'b1;
                pc_r <= stack_top;
            end
            // flags move only by a bus write, never by execution
            if (wr_ok && wa_status)
                status_r <= stat_mrg[7:0];
        end
    end

    // reset flag survives the soft reset it reports
    always_ff @(posedge mclk)
    begin
        if (rst)
            ri_r <= RI_RST;
        else if (ex_srst)
            ri_r <= 1'b0;
        else if (wr_ok && wa_pwrctl && wstrb_r[0])
            ri_r <= wdata_r[RI_BIT];
    end

    // reset request pulse and last executed instruction
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            soft_rst_r <= 1'b0;
            last_r <= 8'h00;
            lastop_r <= 4'h0;
        end
        else
        begin
            soft_rst_r <= ex_srst;
            if (exec)
            begin
                last_r <= arg;
                lastop_r <= op;
            end
        end
    end

    // data memory port, registered
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            dm_we_r <= 1'b0;
            dm_addr_r <= 16'h0000;
            dm_wdata_r <= 8'h00;
        end
        else
        begin
            dm_we_r <= ex_file || ex_ind;
            if (ex_file || ex_ind)
            begin
                dm_addr_r <= ex_ind ? ind_ea : file_ea;
                dm_wdata_r <= acc_r;
            end
        end
    end

    // outputs
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign dm_we = dm_we_r;
    assign dm_addr = dm_addr_r;
    assign dm_wdata = dm_wdata_r;
    assign stk_pop = ret_pop;
    assign dev_reset_req = soft_rst_r;
    assign pc = pc_r;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst || soft_rst_r);

    bank_load_a: assert property (ex_bank |=>
        bank_r == $past(arg[BANK_W-1:0]) && !busy)
        else $error("bank select not loaded");
    pch_load_a: assert property (ex_pch |=>
        pch_r == $past(arg[PCH_W-1:0]))
        else $error("pc-high latch not loaded");
    acc_load_a: assert property (ex_acc |=>
        acc_r == $past(arg) && !busy)
        else $error("accumulator literal not loaded");
    file_store_a: assert property (ex_file && !win0 && !win1 |=>
        dm_we && dm_wdata == $past(acc_r) && dm_addr[6:0] == $past(faddr))
        else $error("file store wrong");
    pre_mode_a: assert property (ex_ind && !arg[IND_REL_BIT] &&
        arg[1:0] == MODE_PRE_INC && !ind_sel |=>
        dm_addr == $past(fsr0_r) + PTR_ONE && fsr0_r == dm_addr)
        else $error("preincrement address wrong");
    rel_keep_a: assert property (ex_ind && arg[IND_REL_BIT] |=>
        $stable(fsr0_r) && $stable(fsr1_r))
        else $error("relative store moved pointer");
    window_a: assert property (ex_file && win1 |=>
        dm_addr == $past(fsr1_r))
        else $error("window not redirected");
    wrap_dec_a: assert property (ex_ind && !ind_sel &&
        !arg[IND_REL_BIT] && arg[1:0] == MODE_POST_DEC &&
        fsr0_r == PTR_RST |=> fsr0_r == PTR_MINUS_ONE)
        else $error("pointer did not wrap");
    status_keep_a: assert property (exec |=> $stable(status_r))
        else $error("status changed by execution");
    // own disable: the default one would mask the very pulse checked here
    soft_reset_a: assert property (disable iff (rst) ex_srst |=>
        dev_reset_req && !ri_r ##1 !dev_reset_req)
        else $error("software reset wrong");
    gie_set_a: assert property (ex_ret |-> stk_pop ##1
        intctl_r[GIE_BIT] && pc == $past(stack_top))
        else $error("return did not enable interrupts");
endmodule
`default_nettype wire

// ==== tb/lmr_far_model.sv ====
// far-side model: data memory write capture and hardware return stack
`default_nettype none
module lmr_far_model
#(
    parameter int PC_W = 15
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic dm_we,
    input wire logic [15:0] dm_addr,
    input wire logic [7:0] dm_wdata,
    input wire logic stk_pop,
    output logic [PC_W-1:0] stack_top,
    output logic [15:0] last_addr,
    output logic [7:0] last_data,
    output logic [7:0] pop_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] sp_r; // stack depth, full at reset
    logic [PC_W-1:0] top_val; // return address held at the top
    // each depth shows a different return address
    assign top_val = PC_W'({11'h2A0, sp_r});
    // value only valid in the pop cycle, so show its inverse otherwise
    assign stack_top = stk_pop ? top_val : ~top_val;
    // pop moves the depth, writes are captured for the bench
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            sp_r <= 4'hF;
            pop_cnt <= 8'h00;
        end
        else if (stk_pop)
        begin
            sp_r <= sp_r - 4'h1;
            pop_cnt <= pop_cnt + 8'h01;
        end
        if (dm_we)
        begin
            last_addr <= dm_addr;
            last_data <= dm_wdata;
        end
    end
endmodule
`default_nettype wire

// ==== tb/tb_literal_move_return_exec.sv ====
// self-checking bench for the literal/move/return executor
`default_nettype none
module tb_literal_move_return_exec
    import lmr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [11:0] ins; logic [5:0] ra;
        logic [31:0] ex;} lmr_row_t;
    logic mclk = 1'b0; // 40 MHz clock
    logic rst = 1'b1; // synchronous reset
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [5:0] awaddr = 6'h00, araddr = 6'h00;
    logic [31:0] wdata = 32'h00000000;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic dm_we, stk_pop, dev_reset_req;
    logic [15:0] dm_addr, last_addr;
    logic [7:0] dm_wdata, last_data, pop_cnt;
    logic [14:0] stack_top, pc;
    int fails = 0, num_checks = 0, rq_cnt = 0, i;
    logic [1:0] r;
    logic [31:0] d;
    // ordinary cases: instruction, register to read back, expected value
    lmr_row_t rows [5] = '{'{12'h11F, REG_BANK, 32'h1F},
        '{12'h27F, REG_PCH, 32'h7F}, '{12'h35A, REG_ACC, 32'h5A},
        '{12'h100, REG_BANK, 32'h0}, '{12'h200, REG_PCH, 32'h0}};
    // pointer chain from FFFF through all four modes, both wraps
    logic [15:0] ea [4] = '{16'h0000, 16'hFFFF, 16'hFFFF, 16'h0000};
    logic [15:0] np [4] = '{16'h0000, 16'hFFFF, 16'h0000, 16'hFFFF};
    always #12.5 mclk = ~mclk;
    lmr_exec dut (.mclk(mclk), .rst(rst), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .dm_we(dm_we), .dm_addr(dm_addr),
        .dm_wdata(dm_wdata), .stk_pop(stk_pop), .stack_top(stack_top),
        .dev_reset_req(dev_reset_req), .pc(pc));
    lmr_far_model far (.mclk(mclk), .rst(rst), .dm_we(dm_we),
        .dm_addr(dm_addr), .dm_wdata(dm_wdata), .stk_pop(stk_pop),
        .stack_top(stack_top), .last_addr(last_addr),
        .last_data(last_data), .pop_cnt(pop_cnt));
    // count reset request pulses, one per software reset expected
    always @(posedge mclk)
        if (dev_reset_req === 1'b1) rq_cnt++;
    // one compare for every value kind, widened to a word
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH %s exp=%h got=%h", nm, e, g);
        end
    endtask
    // write: address and data offered together, each released when taken
    task automatic wr(input logic [5:0] a, input logic [31:0] v,
        output logic [1:0] rs);
        @(posedge mclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever
        begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1)
            begin
                rs = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask
    // read: address held until taken, data taken with rvalid
    task automatic rd(input logic [5:0] a, output logic [31:0] v);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever
        begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1)
            begin
                v = rdata;
                rready <= 1'b0;
                break;
            end
        end
    endtask
    // read a register and compare it
    task automatic rchk(input string nm, input logic [5:0] a,
        input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        chk(nm, e, v);
    endtask
    // execute one instruction, then wait until the busy bit drops
    task automatic ex(input logic [11:0] ins);
        logic [1:0] rs;
        logic [31:0] v;
        wr(REG_INSTR, {20'h0, ins}, rs);
        chk("instr_resp", {30'h0, RESP_OKAY}, {30'h0, rs});
        do rd(REG_INSTR, v); while (v[INSTR_BUSY_BIT] !== 1'b0);
    endtask
    task automatic test_done();
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // watchdog cuts a hang short
    initial
    begin
        repeat (20000) @(posedge mclk);
        fails++;
        test_done();
    end
    initial
    begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        rchk("pwr_rst", REG_PWRCTL, 32'h4);
        rchk("acc_rst", REG_ACC, 32'h0);
        chk("pc_rst", 32'h0, {17'h0, pc});
        wr(REG_STATUS, 32'hA5, r);
        // literal loads through the row table
        for (i = 0; i < 5; i++)
        begin
            ex(rows[i].ins);
            rchk("row", rows[i].ra, rows[i].ex);
        end
        // indirect store, all modes, wrapping at both ends
        wr(REG_FSR0, 32'hFFFF, r);
        for (i = 0; i < 4; i++)
        begin
            ex(12'h500 | 12'(i));
            chk("ind_addr", {16'h0, ea[i]}, {16'h0, last_addr});
            chk("ind_data", 32'h5A, {24'h0, last_data});
            rchk("fsr0", REG_FSR0, {16'h0, np[i]});
        end
        // relative offsets at both ends of the signed range
        wr(REG_FSR1, 32'h0010, r);
        ex(12'h5E0);
        chk("rel_lo", 32'hFFF0, {16'h0, last_addr});
        ex(12'h5DF);
        chk("rel_hi", 32'h002F, {16'h0, last_addr});
        rchk("fsr1", REG_FSR1, 32'h0010);
        rchk("status", REG_STATUS, 32'hA5);
        // direct store and the two window aliases
        ex(12'h425);
        chk("file", 32'h005A0025, {8'h0, last_data, last_addr});
        ex(12'h400);
        chk("win0", 32'hFFFF, {16'h0, last_addr});
        ex(12'h401);
        chk("win1", 32'h0010, {16'h0, last_addr});
        // two returns pop two different stack entries
        ex(12'h700);
        rchk("pc1", REG_PC, 32'h2A0F);
        rchk("gie", REG_INTCTL, 32'h80);
        chk("rd_ok", {30'h0, RESP_OKAY}, {30'h0, rresp});
        chk("pc_port", 32'h2A0F, {17'h0, pc});
        ex(12'h700);
        rchk("pc2", REG_PC, 32'h2A0E);
        chk("pops", 32'h2, {24'h0, pop_cnt});
        // refused writes: unmapped and read-only places
        wr(6'h3C, 32'h1, r);
        chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
        rd(6'h3C, d);
        chk("rd_err", {30'h0, RESP_SLVERR}, {30'h0, rresp});
        // idle instruction leaves the accumulator alone
        ex(12'h000);
        rchk("idle_acc", REG_ACC, 32'h5A);
        wr(REG_BANK, 32'h1, r);
        chk("ro_bank", {30'h0, RESP_SLVERR}, {30'h0, r});
        // software reset: one request pulse, flag cleared, state cleared
        ex(12'h600);
        chk("rst_req", 32'h1, rq_cnt);
        rchk("pwr_flag", REG_PWRCTL, 32'h0);
        rchk("acc_clr", REG_ACC, 32'h0);
        test_done();
    end
endmodule
`default_nettype wire
